// file: hw/ars_pkg.sv
`default_nettype none
package ars_pkg;
    // ----------------------------------------
    // command word layout
    // ----------------------------------------
    localparam int unsigned CMD_RW_BIT     = 15;
    localparam int unsigned CMD_ADDR_HI    = 14;
    localparam int unsigned CMD_ADDR_LO    = 9;
    localparam int unsigned CMD_RSVD_BIT   = 8;
    // ----------------------------------------
    // register indices (6-bit target_reg_index)
    // ----------------------------------------
    localparam logic [5:0] IDX_RANGE_A_HIGH = 6'h05;
    localparam logic [5:0] IDX_RANGE_B_LOW  = 6'h06;
    localparam logic [5:0] IDX_RANGE_B_HIGH = 6'h07;
    localparam logic [5:0] IDX_STATUS       = 6'h08;
    // ----------------------------------------
    // apb byte offsets
    // ----------------------------------------
    localparam logic [7:0] OFS_CMD          = 8'h00;
    localparam logic [7:0] OFS_RDATA        = 8'h04;
    localparam logic [7:0] OFS_CTRL         = 8'h08;
    localparam logic [7:0] OFS_RANGE_A_HIGH = 8'h14;
    localparam logic [7:0] OFS_RANGE_B_LOW  = 8'h18;
    localparam logic [7:0] OFS_RANGE_B_HIGH = 8'h1C;
    localparam logic [7:0] OFS_STATUS       = 8'h20;
    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [15:0] RST_RANGE_A_HIGH = 16'h0AFF;
    localparam logic [15:0] RST_RANGE_B_LOW  = 16'h0CFF;
    localparam logic [15:0] RST_RANGE_B_HIGH = 16'h0EFF;
    localparam logic [15:0] RST_STATUS       = 16'h0000;
    localparam logic [7:0]  RST_SPANS        = 8'hFF;
    // ----------------------------------------
    // span codes and channel indices
    // ----------------------------------------
    localparam logic [1:0] SPAN_10V_A  = 2'h0;
    localparam logic [1:0] SPAN_2V5    = 2'h1;
    localparam logic [1:0] SPAN_5V     = 2'h2;
    localparam logic [1:0] SPAN_10V_B  = 2'h3;
    localparam logic [3:0] PICK_AIN_MAX   = 4'h7;
    localparam logic [3:0] PICK_SUPPLY    = 4'h8;
    localparam logic [3:0] PICK_REGULATOR = 4'h9;
    localparam logic [3:0] PICK_TEST      = 4'hB;
    typedef enum logic [1:0] {SPAN_PM2V5, SPAN_PM5V, SPAN_PM10V} ars_span_e;
endpackage : ars_pkg
`default_nettype wire

// file: hw/ars_span_decode.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// one span field to a one-hot span
// ----------------------------------------
module ars_span_decode (
    input  wire logic [1:0] code,
    output logic      [2:0] span_onehot
);
    always_comb begin
        case (code)
            ars_pkg::SPAN_2V5: span_onehot = 3'h1;
            ars_pkg::SPAN_5V:  span_onehot = 3'h2;
            default:           span_onehot = 3'h4;
        endcase
    end
endmodule : ars_span_decode
`default_nettype wire

// file: hw/ars_index_check.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// legal channel-select code filter
// ----------------------------------------
module ars_index_check (
    input  wire logic [3:0] pick,
    output logic            legal
);
    always_comb begin
        legal = (pick <= ars_pkg::PICK_AIN_MAX) || (pick == ars_pkg::PICK_SUPPLY) ||
                (pick == ars_pkg::PICK_REGULATOR) || (pick == ars_pkg::PICK_TEST);
    end
endmodule : ars_index_check
`default_nettype wire

// file: hw/ars_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - command bit 15: 0 read, 1 write
// - bits 14:9 carry register index
// - range bit 8 reserved, reads zero
// - span codes: 00/11 10V, 01 2.5V, 10 5V
// - group-A high fields, reset 11 each
// - group-B low at 0x6, reset 0xCFF
// - group-B high at 0x7, reset 0xEFF
// - status 0x8, bits 15:12 last A index
// - status bits 11:8 last B index
// - status bits 7:0 hold CRC result
// - indices use channel-select encoding
// - append status to results when enabled
module ars_regs (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        conv_done_a,
    input  wire logic [3:0]  conv_index_a,
    input  wire logic        conv_done_b,
    input  wire logic [3:0]  conv_index_b,
    input  wire logic        crc_valid,
    input  wire logic [7:0]  crc_value,
    input  wire logic        result_valid,
    input  wire logic [15:0] result_data,
    output logic             out_valid,
    output logic      [31:0] out_data,
    output logic             append_status_enable,
    output logic      [7:0]  range_group_a_high,
    output logic      [7:0]  range_group_b_low,
    output logic      [7:0]  range_group_b_high,
    output logic      [11:0] span_onehot_a_high,
    output logic      [23:0] span_onehot_b
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [7:0]  a_high;
        logic [7:0]  b_low;
        logic [7:0]  b_high;
        logic [3:0]  last_a;
        logic [3:0]  last_b;
        logic [7:0]  crc;
        logic        append_en;
        logic [15:0] rdata;
        logic [31:0] prdata;
        logic        out_valid;
        logic [31:0] out_data;
    } ars_state_s;

    ars_state_s st;
    ars_state_s next_st;

    logic        acc;
    logic        wr;
    logic        rd;
    logic        legal_a;
    logic        legal_b;
    logic        cmd_write;
    logic [5:0]  cmd_index;
    logic [3:0]  last_conv_index_a;
    logic [3:0]  last_conv_index_b;
    logic [7:0]  crc_result;
    logic [15:0] status_word;
    logic [15:0] word_a_high;
    logic [15:0] word_b_low;
    logic [15:0] word_b_high;

    assign acc               = psel && penable;
    assign wr                = acc && pwrite;
    assign rd                = acc && !pwrite;
    assign cmd_write         = pwdata[ars_pkg::CMD_RW_BIT];
    assign cmd_index         = pwdata[ars_pkg::CMD_ADDR_HI:ars_pkg::CMD_ADDR_LO];
    assign last_conv_index_a = st.last_a;
    assign last_conv_index_b = st.last_b;
    assign crc_result        = st.crc;
    assign status_word       = {last_conv_index_a, last_conv_index_b, crc_result};

    // ----------------------------------------
    // range read words
    // ----------------------------------------
    assign word_a_high = {1'b0, ars_pkg::IDX_RANGE_A_HIGH, 1'b0, st.a_high};
    assign word_b_low  = {1'b0, ars_pkg::IDX_RANGE_B_LOW, 1'b0, st.b_low};
    assign word_b_high = {1'b0, ars_pkg::IDX_RANGE_B_HIGH, 1'b0, st.b_high};

    // ----------------------------------------
    // channel index filters
    // ----------------------------------------
    ars_index_check u_chk_a (
        .pick  (conv_index_a),
        .legal (legal_a)
    );
    ars_index_check u_chk_b (
        .pick  (conv_index_b),
        .legal (legal_b)
    );

    // ----------------------------------------
    // per-channel span fields
    // ----------------------------------------
    logic [1:0] span_a_ch4;
    logic [1:0] span_a_ch5;
    logic [1:0] span_a_ch6;
    logic [1:0] span_a_ch7;

    logic [1:0] span_b_ch0;
    logic [1:0] span_b_ch1;
    logic [1:0] span_b_ch2;
    logic [1:0] span_b_ch3;
    logic [1:0] span_b_ch4;
    logic [1:0] span_b_ch5;
    logic [1:0] span_b_ch6;
    logic [1:0] span_b_ch7;

    assign span_a_ch4 = st.a_high[1:0];
    assign span_a_ch5 = st.a_high[3:2];
    assign span_a_ch6 = st.a_high[5:4];
    assign span_a_ch7 = st.a_high[7:6];

    assign span_b_ch0 = st.b_low[1:0];
    assign span_b_ch1 = st.b_low[3:2];
    assign span_b_ch2 = st.b_low[5:4];
    assign span_b_ch3 = st.b_low[7:6];
    assign span_b_ch4 = st.b_high[1:0];
    assign span_b_ch5 = st.b_high[3:2];
    assign span_b_ch6 = st.b_high[5:4];
    assign span_b_ch7 = st.b_high[7:6];

    // ----------------------------------------
    // span decoders
    // ----------------------------------------
    ars_span_decode u_a_ch4 (
        .code        (span_a_ch4),
        .span_onehot (span_onehot_a_high[2:0])
    );

    ars_span_decode u_a_ch5 (
        .code        (span_a_ch5),
        .span_onehot (span_onehot_a_high[5:3])
    );

    ars_span_decode u_a_ch6 (
        .code        (span_a_ch6),
        .span_onehot (span_onehot_a_high[8:6])
    );

    ars_span_decode u_a_ch7 (
        .code        (span_a_ch7),
        .span_onehot (span_onehot_a_high[11:9])
    );

    ars_span_decode u_b_ch0 (
        .code        (span_b_ch0),
        .span_onehot (span_onehot_b[2:0])
    );

    ars_span_decode u_b_ch1 (
        .code        (span_b_ch1),
        .span_onehot (span_onehot_b[5:3])
    );

    ars_span_decode u_b_ch2 (
        .code        (span_b_ch2),
        .span_onehot (span_onehot_b[8:6])
    );

    ars_span_decode u_b_ch3 (
        .code        (span_b_ch3),
        .span_onehot (span_onehot_b[11:9])
    );

    ars_span_decode u_b_ch4 (
        .code        (span_b_ch4),
        .span_onehot (span_onehot_b[14:12])
    );

    ars_span_decode u_b_ch5 (
        .code        (span_b_ch5),
        .span_onehot (span_onehot_b[17:15])
    );

    ars_span_decode u_b_ch6 (
        .code        (span_b_ch6),
        .span_onehot (span_onehot_b[20:18])
    );

    ars_span_decode u_b_ch7 (
        .code        (span_b_ch7),
        .span_onehot (span_onehot_b[23:21])
    );

    // ----------------------------------------
    // command word access
    // ----------------------------------------
    function automatic logic [15:0] read_index(input logic [5:0] idx, input ars_state_s s,
                                               input logic [15:0] stw);
        logic [15:0] v;
        v = 16'h0000;
        case (idx)
            ars_pkg::IDX_RANGE_A_HIGH: v = {1'b0, idx, 1'b0, s.a_high};
            ars_pkg::IDX_RANGE_B_LOW:  v = {1'b0, idx, 1'b0, s.b_low};
            ars_pkg::IDX_RANGE_B_HIGH: v = {1'b0, idx, 1'b0, s.b_high};
            ars_pkg::IDX_STATUS:       v = stw;
            default:                   v = 16'h0000;
        endcase
        return v;
    endfunction : read_index

    always_comb begin
        next_st           = st;
        next_st.out_valid = 1'b0;
        if (conv_done_a && legal_a) begin
            next_st.last_a = conv_index_a;
        end
        if (conv_done_b && legal_b) begin
            next_st.last_b = conv_index_b;
        end
        if (crc_valid) begin
            next_st.crc = crc_value;
        end
        if (result_valid) begin
            next_st.out_valid = 1'b1;
            if (st.append_en) begin
                next_st.out_data = {result_data, status_word};
            end else begin
                next_st.out_data = {16'h0000, result_data};
            end
        end
        if (wr) begin
            case (paddr)
                ars_pkg::OFS_CMD: begin
                    if (cmd_write) begin
                        case (cmd_index)
                            ars_pkg::IDX_RANGE_A_HIGH: next_st.a_high = pwdata[7:0];
                            ars_pkg::IDX_RANGE_B_LOW:  next_st.b_low  = pwdata[7:0];
                            ars_pkg::IDX_RANGE_B_HIGH: next_st.b_high = pwdata[7:0];
                            default:                   next_st.b_high = st.b_high;
                        endcase
                    end else begin
                        next_st.rdata = read_index(cmd_index, st, status_word);
                    end
                end
                ars_pkg::OFS_CTRL:         next_st.append_en = pwdata[0];
                ars_pkg::OFS_RANGE_A_HIGH: next_st.a_high    = pwdata[7:0];
                ars_pkg::OFS_RANGE_B_LOW:  next_st.b_low     = pwdata[7:0];
                ars_pkg::OFS_RANGE_B_HIGH: next_st.b_high    = pwdata[7:0];
                default:                   next_st.append_en = st.append_en;
            endcase
        end
        if (rd) begin
            case (paddr)
                ars_pkg::OFS_RDATA:        next_st.prdata = {16'h0000, st.rdata};
                ars_pkg::OFS_CTRL:         next_st.prdata = {31'h00000000, st.append_en};
                ars_pkg::OFS_RANGE_A_HIGH: next_st.prdata = {16'h0000, word_a_high};
                ars_pkg::OFS_RANGE_B_LOW:  next_st.prdata = {16'h0000, word_b_low};
                ars_pkg::OFS_RANGE_B_HIGH: next_st.prdata = {16'h0000, word_b_high};
                ars_pkg::OFS_STATUS:       next_st.prdata = {16'h0000, status_word};
                default:                   next_st.prdata = 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st           <= '0;
            st.a_high    <= ars_pkg::RST_SPANS;
            st.b_low     <= ars_pkg::RST_SPANS;
            st.b_high    <= ars_pkg::RST_SPANS;
            st.last_a    <= ars_pkg::RST_STATUS[15:12];
            st.last_b    <= ars_pkg::RST_STATUS[11:8];
            st.crc       <= ars_pkg::RST_STATUS[7:0];
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign pready               = 1'b1;
    assign pslverr              = 1'b0;
    assign prdata               = st.prdata;
    assign out_valid            = st.out_valid;
    assign out_data             = st.out_data;
    assign append_status_enable = st.append_en;
    assign range_group_a_high   = st.a_high;
    assign range_group_b_low    = st.b_low;
    assign range_group_b_high   = st.b_high;
endmodule : ars_regs
`default_nettype wire

// file: testbench/ars_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ars_regs_assertions (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        result_valid,
    input wire logic [15:0] result_data,
    input wire logic        out_valid,
    input wire logic [31:0] out_data,
    input wire logic        append_status_enable,
    input wire logic [7:0]  range_group_a_high,
    input wire logic [7:0]  range_group_b_low,
    input wire logic [7:0]  range_group_b_high,
    input wire logic [23:0] span_onehot_b
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr;
    assign wr = psel && penable && pwrite && clk_en;
    sequence s_plain; result_valid && clk_en && !append_status_enable; endsequence
    sequence s_app; result_valid && clk_en && append_status_enable; endsequence
    a_zero_wait: assert property (psel && penable |-> pready && !pslverr)
        else $error("access not answered at once");
    a_plain_out: assert property (s_plain |=> out_valid && out_data == {16'h0000, $past(result_data)})
        else $error("plain result word wrong");
    a_append_out: assert property (s_app |=> out_valid && out_data[31:16] == $past(result_data))
        else $error("appended result word wrong");
    a_no_spurious: assert property (clk_en && !result_valid |=> !out_valid)
        else $error("output pulse without result");
    a_freeze_hold: assert property (!clk_en |=> $stable(out_valid) && $stable(range_group_b_low))
        else $error("state moved while frozen");
    a_bl_write: assert property (wr && paddr == ars_pkg::OFS_RANGE_B_LOW |=> range_group_b_low == $past(pwdata[7:0]))
        else $error("group b low not written");
    a_ah_write: assert property (wr && paddr == ars_pkg::OFS_RANGE_A_HIGH |=> range_group_a_high == $past(pwdata[7:0]))
        else $error("group a high not written");
    a_bh_hold: assert property (!wr |=> $stable(range_group_b_high))
        else $error("group b high changed without write");
    a_span_quarter: assert property (range_group_b_low[1:0] == 2'h1 |-> span_onehot_b[2:0] == 3'h1)
        else $error("code 01 span wrong");
    a_span_full: assert property (range_group_b_low[3:2] inside {2'h0, 2'h3} |-> span_onehot_b[5:3] == 3'h4)
        else $error("full span code wrong");
endmodule : ars_regs_assertions
bind ars_regs ars_regs_assertions u_chk (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .result_valid, .result_data, .out_valid, .out_data, .append_status_enable,
    .range_group_a_high, .range_group_b_low, .range_group_b_high, .span_onehot_b);
`default_nettype wire

// file: testbench/ars_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module ars_conv_model (
    input  wire logic        pclk,
    output var  logic        conv_done_a,
    output var  logic [3:0]  conv_index_a,
    output var  logic        conv_done_b,
    output var  logic [3:0]  conv_index_b,
    output var  logic        crc_valid,
    output var  logic [7:0]  crc_value,
    output var  logic        result_valid,
    output var  logic [15:0] result_data
);
    initial begin
        {conv_done_a, conv_done_b, crc_valid, result_valid} = 4'h0;
        {conv_index_a, conv_index_b, crc_value, result_data} = 32'h0;
    end
    // one conversion on both converters with its crc
    task automatic convert(input logic [3:0] ia, input logic [3:0] ib, input logic [7:0] crc);
        @(posedge pclk);
        {conv_done_a, conv_done_b, crc_valid} <= 3'h7;
        {conv_index_a, conv_index_b, crc_value} <= {ia, ib, crc};
        @(posedge pclk);
        {conv_done_a, conv_done_b, crc_valid} <= 3'h0;
        {conv_index_a, conv_index_b, crc_value} <= ~{ia, ib, crc};
        #1;
    endtask : convert
    task automatic send(input logic [15:0] d);
        @(posedge pclk);
        result_valid <= 1'b1;
        result_data <= d;
        @(posedge pclk);
        result_valid <= 1'b0;
        result_data <= ~d;
        #1;
    endtask : send
endmodule : ars_conv_model
`default_nettype wire

// file: testbench/tb_adc_range_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_range_status_regs;
    logic        pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, out_valid, append_status_enable;
    logic        conv_done_a, conv_done_b, crc_valid, result_valid;
    logic [3:0]  conv_index_a, conv_index_b;
    logic [7:0]  paddr, crc_value, range_group_a_high, range_group_b_low, range_group_b_high;
    logic [15:0] result_data;
    logic [11:0] span_onehot_a_high;
    logic [31:0] pwdata, prdata, out_data;
    logic [23:0] span_onehot_b;
    int          failures = 0;
    int          checks_done = 0;
    ars_regs DUT (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .conv_done_a, .conv_index_a, .conv_done_b, .conv_index_b, .crc_valid, .crc_value, .result_valid,
        .result_data, .out_valid, .out_data, .append_status_enable, .range_group_a_high, .range_group_b_low,
        .range_group_b_high, .span_onehot_a_high, .span_onehot_b);
    ars_conv_model conv (.pclk, .conv_done_a, .conv_index_a, .conv_done_b, .conv_index_b, .crc_valid, .crc_value,
        .result_valid, .result_data);
    task automatic stop_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("BAD %0t got %h expected %h", $time, got, exp);
            failures++;
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        {psel, penable} <= 2'h0;
        #1;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        @(posedge pclk);
        #1;
        chk(prdata, exp);
    endtask : rd
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        repeat (3000) @(posedge pclk);
        failures++;
        stop_test();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
        clk_en = 1'b1;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(8'h14, 32'h0AFF);
        rd(8'h18, 32'h0CFF);
        rd(8'h1C, 32'h0EFF);
        rd(8'h20, 32'h0000);
        apb(1'b1, 8'h18, 32'h01E4);
        rd(8'h18, 32'h0CE4);
        chk({20'h0, span_onehot_b[11:0]}, 32'h088C);
        apb(1'b1, 8'h14, 32'h0036);
        rd(8'h14, 32'h0A36);
        chk({20'h0, span_onehot_a_high}, 32'h090A);
        apb(1'b1, 8'h00, {16'h0, 1'b1, ars_pkg::IDX_RANGE_B_HIGH, 9'h01B});
        chk({24'h0, range_group_b_high}, 32'h001B);
        apb(1'b1, 8'h00, {16'h0, 1'b0, ars_pkg::IDX_RANGE_B_HIGH, 9'h000});
        rd(8'h04, 32'h0E1B);
        conv.convert(4'h5, 4'h9, 8'h3C);
        rd(8'h20, 32'h593C);
        conv.convert(4'hA, 4'hB, 8'hC3);
        rd(8'h20, 32'h5BC3);
        @(posedge pclk);
        clk_en <= 1'b0;
        conv.convert(4'h1, 4'h2, 8'hAA);
        @(posedge pclk);
        clk_en <= 1'b1;
        rd(8'h20, 32'h5BC3);
        apb(1'b1, 8'h20, 32'hFFFF);
        rd(8'h20, 32'h5BC3);
        apb(1'b1, 8'h00, {16'h0, 1'b0, ars_pkg::IDX_STATUS, 9'h000});
        rd(8'h04, 32'h5BC3);
        conv.send(16'h1234);
        chk({out_valid, out_data[30:0]}, 32'h80001234);
        apb(1'b1, 8'h08, 32'h0001);
        rd(8'h08, 32'h0001);
        chk({31'h0, append_status_enable}, 32'h0001);
        conv.send(16'hBEEF);
        chk(out_data, 32'hBEEF5BC3);
        apb(1'b1, 8'h3C, 32'h0055);
        rd(8'h3C, 32'h0000);
        stop_test();
    end
endmodule : tb_adc_range_status_regs
`default_nettype wire
